// file: design/ppm_pkg.sv
// Constants and types for the peak power and monitor control block
package ppm_pkg;
  localparam int CLK_HZ = 40_000_000;
  // Audible noise floor and the longest gap it allows, rounded down
  localparam int NOISE_FLOOR_HZ = 25_000;
  localparam int NOISE_GAP_CYC = CLK_HZ / NOISE_FLOOR_HZ;
  // Peak timer tick, durations are counted in these units
  localparam int TICK_NS = 1000;
  localparam int TICK_CYC = (TICK_NS * (CLK_HZ / 1_000_000)) / 1000;
  // Optimizer floor and limit code step
  localparam int ICO_MIN_MA = 500;
  localparam int LIM_LSB_MA = 50;
  localparam int PCT_FULL = 100;
  // Spread selections and their percentages
  localparam logic [1:0] SPREAD_OFF = 2'h0;
  localparam logic [1:0] SPREAD_2 = 2'h1;
  localparam logic [1:0] SPREAD_4 = 2'h2;
  localparam logic [1:0] SPREAD_6 = 2'h3;
  localparam int SPREAD_2_PCT = 2;
  localparam int SPREAD_4_PCT = 4;
  localparam int SPREAD_6_PCT = 6;
  // Power monitor configurations
  localparam logic [1:0] PMON_ALL = 2'h0;
  localparam logic [1:0] PMON_BUS = 2'h1;
  localparam logic [1:0] PMON_RSVD = 2'h2;
  localparam logic [1:0] PMON_OFF = 2'h3;
  // Host configuration carried as one group
  typedef struct packed {
    logic noise_guard_en;
    logic freq_sel;
    logic [1:0] spread_sel;
    logic in_gain_hi;
    logic bat_gain_hi;
    logic [1:0] pmon_cfg;
    logic otg_bat_only;
    logic in_res_5m;
    logic bat_res_5m;
    logic surge_en;
    logic droop_en;
    logic ico_request;
  } ppm_cfg_s;
  localparam ppm_cfg_s CFG_RST = '{noise_guard_en: 1'b0, freq_sel: 1'b0,
    spread_sel: SPREAD_OFF, in_gain_hi: 1'b0, bat_gain_hi: 1'b0,
    pmon_cfg: PMON_OFF, otg_bat_only: 1'b0, in_res_5m: 1'b0,
    bat_res_5m: 1'b0, surge_en: 1'b0, droop_en: 1'b0, ico_request: 1'b0};
  // Comparator flags from the analog side
  typedef struct packed {
    logic light_load;
    logic demand;
    logic in_over_lim;
    logic in_under_vlim;
    logic sys_below_bat;
    logic sys_below_min;
    logic bat_dischg;
    logic uvlo_ok;
    logic otg_mode;
  } ppm_sense_s;
  localparam int SENSE_W = $bits(ppm_sense_s);
  typedef enum logic [1:0] {PK_IDLE, PK_OVLD, PK_HOLD} ppm_pk_e;
endpackage

// file: design/ppm_ctrl.sv
// Peak power, pulse skipping, dithering and monitor control
`timescale 1ns/1ps
`default_nettype none
module ppm_ctrl #(
  parameter int PER_LO_CYC = 50,
  parameter int PER_HI_CYC = 34,
  parameter int LIM_W = 7,
  parameter int TIME_W = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire ppm_pkg::ppm_cfg_s cfg_in,
  input wire logic [LIM_W-1:0] input_current_limit,
  input wire logic [7:0] overload_limit_pct,
  input wire logic [TIME_W-1:0] overload_duration,
  input wire logic [TIME_W-1:0] peak_cycle_period,
  input wire ppm_pkg::ppm_sense_s sense_pin,
  output logic switch_pulse,
  output logic pulse_skipping_mode,
  output logic input_monitor_gain_hi,
  output logic battery_monitor_gain_hi,
  output logic input_monitor_valid,
  output logic power_bus_term_en,
  output logic power_bat_term_en,
  output logic input_res_5m,
  output logic battery_res_5m,
  output logic charge_reduce,
  output logic battery_supplement,
  output logic ico_allowed,
  output logic [LIM_W+1:0] active_limit,
  output logic peak_level2,
  output logic charge_disable,
  output logic peak_active
);
  // Power monitor term decode: {bus, battery}
  function automatic logic [1:0] pmon_terms(input logic [1:0] c, input logic bat_only,
                                           input logic otg);
    logic [1:0] t;
    t = 2'b00;
    case (c)
      ppm_pkg::PMON_ALL: t = (otg && bat_only) ? 2'b01 : 2'b11;
      ppm_pkg::PMON_BUS: t = otg ? 2'b00 : 2'b10;
      default: t = 2'b00;
    endcase
    return t;
  endfunction

  // Spread percentage for a selection
  function automatic int spread_pct(input logic [1:0] s);
    int p;
    p = 0;
    case (s)
      ppm_pkg::SPREAD_2: p = ppm_pkg::SPREAD_2_PCT;
      ppm_pkg::SPREAD_4: p = ppm_pkg::SPREAD_4_PCT;
      ppm_pkg::SPREAD_6: p = ppm_pkg::SPREAD_6_PCT;
      default: p = 0;
    endcase
    return p;
  endfunction

  ppm_pkg::ppm_cfg_s cfg;
  logic [ppm_pkg::SENSE_W-1:0] sync1;
  logic [ppm_pkg::SENSE_W-1:0] sync2;
  ppm_pkg::ppm_sense_s sn;

  // Config registered from cfg_in every clock, reset defaults hold only while rst_n is low
  // Dither reset off
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg <= ppm_pkg::CFG_RST;
    end else begin
      cfg <= cfg_in;
    end
  end

  // Two-stage synchronisers, one per comparator flag
  genvar gi;
  generate
    for (gi = 0; gi < ppm_pkg::SENSE_W; gi++) begin : g_sync
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          sync1[gi] <= 1'b0;
          sync2[gi] <= 1'b0;
        end else begin
          sync1[gi] <= sense_pin[gi];
          sync2[gi] <= sync1[gi];
        end
      end
    end
  endgenerate
  assign sn = ppm_pkg::ppm_sense_s'(sync2);

  // Switching period with dither offset applied
  logic [15:0] sw_cnt;
  logic signed [7:0] dith_ofs;
  logic dith_up;
  logic [7:0] base_per;
  logic signed [7:0] span;
  logic [15:0] target;
  logic per_done;
  logic gap_done;
  logic fire;

  assign base_per = cfg.freq_sel ? 8'(PER_HI_CYC) : 8'(PER_LO_CYC);
  assign span = 8'((int'(base_per) * spread_pct(cfg.spread_sel)) / ppm_pkg::PCT_FULL);
  assign target = 16'(int'(base_per) + int'(dith_ofs));
  assign per_done = (sw_cnt >= target - 16'h0001);
  assign gap_done = (int'(sw_cnt) >= ppm_pkg::NOISE_GAP_CYC - 1);
  // Skip unless demand; guard forces floor
  assign fire = sn.light_load ? ((per_done && sn.demand) ||
                                 (cfg.noise_guard_en && gap_done)) : per_done;

  // Switching counter, saturates while pulses are skipped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sw_cnt <= 16'h0000;
      switch_pulse <= 1'b0;
    end else begin
      switch_pulse <= fire;
      if (fire) begin
        sw_cnt <= 16'h0000;
      end else if (sw_cnt != 16'hffff) begin
        sw_cnt <= sw_cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pulse_skipping_mode <= 1'b0;
    end else begin
      pulse_skipping_mode <= sn.light_load;
    end
  end

  // Triangle sweep of the period, one step per switching pulse
  // Dither sweep within span
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dith_ofs <= 8'sh00;
      dith_up <= 1'b1;
    end else if (cfg.spread_sel == ppm_pkg::SPREAD_OFF) begin
      dith_ofs <= 8'sh00;
      dith_up <= 1'b1;
    end else if (dith_ofs > span || dith_ofs < -span) begin
      dith_ofs <= 8'sh00; // Span shrank, restart from centre
    end else if (fire) begin
      if (dith_up) begin
        if (dith_ofs >= span) begin
          dith_up <= 1'b0;
          dith_ofs <= dith_ofs - 8'sh01;
        end else begin
          dith_ofs <= dith_ofs + 8'sh01;
        end
      end else begin
        if (dith_ofs <= -span) begin
          dith_up <= 1'b1;
          dith_ofs <= dith_ofs + 8'sh01;
        end else begin
          dith_ofs <= dith_ofs - 8'sh01;
        end
      end
    end
  end

  // Current and power monitor configuration
  logic [1:0] terms;
  assign terms = pmon_terms(cfg.pmon_cfg, cfg.otg_bat_only, sn.otg_mode);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      input_monitor_gain_hi <= 1'b0;
      battery_monitor_gain_hi <= 1'b0;
      input_monitor_valid <= 1'b0;
      power_bus_term_en <= 1'b0;
      power_bat_term_en <= 1'b0;
      input_res_5m <= 1'b0;
      battery_res_5m <= 1'b0;
    end else begin
      input_monitor_gain_hi <= cfg.in_gain_hi;
      battery_monitor_gain_hi <= cfg.bat_gain_hi;
      input_monitor_valid <= sn.uvlo_ok;
      power_bus_term_en <= terms[1];
      power_bat_term_en <= terms[0];
      input_res_5m <= cfg.in_res_5m;
      battery_res_5m <= cfg.bat_res_5m;
    end
  end

  // Dynamic power management and optimizer gate
  logic ico_ok;
  assign ico_ok = (int'(input_current_limit) * ppm_pkg::LIM_LSB_MA) >= ppm_pkg::ICO_MIN_MA;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      charge_reduce <= 1'b0;
      battery_supplement <= 1'b0;
      ico_allowed <= 1'b0;
    end else begin
      charge_reduce <= sn.in_over_lim || sn.in_under_vlim || charge_disable;
      battery_supplement <= sn.sys_below_bat && (charge_reduce || charge_disable);
      ico_allowed <= cfg.ico_request && ico_ok;
    end
  end

  // Peak power cycle: level two, then level one with charging held off
  ppm_pkg::ppm_pk_e pk_state;
  logic [TIME_W-1:0] pk_time;
  logic [7:0] tick_cnt;
  logic tick;
  logic surge_trig;
  logic droop_trig;
  logic trig;
  logic [LIM_W+1:0] lim1;
  logic [LIM_W+1:0] lim2;

  assign surge_trig = cfg.surge_en && sn.in_over_lim && sn.bat_dischg;
  assign droop_trig = cfg.droop_en && sn.sys_below_min && !sn.bat_dischg;
  assign trig = surge_trig || droop_trig;
  assign lim1 = (LIM_W+2)'(input_current_limit);
  assign lim2 = (LIM_W+2)'((int'(input_current_limit) * int'(overload_limit_pct))
                           / ppm_pkg::PCT_FULL);

  assign tick = (int'(tick_cnt) == ppm_pkg::TICK_CYC - 1);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt <= 8'h00;
    end else if (pk_state == ppm_pkg::PK_IDLE || tick) begin
      tick_cnt <= 8'h00;
    end else begin
      tick_cnt <= tick_cnt + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pk_state <= ppm_pkg::PK_IDLE;
      pk_time <= '0;
    end else if (!cfg.surge_en && !cfg.droop_en) begin
      pk_state <= ppm_pkg::PK_IDLE;
      pk_time <= '0;
    end else begin
      case (pk_state)
        ppm_pkg::PK_IDLE: begin
          pk_time <= '0;
          if (trig) begin
            pk_state <= ppm_pkg::PK_OVLD;
          end
        end
        ppm_pkg::PK_OVLD: begin
          if (tick) begin
            pk_time <= pk_time + 1'b1;
            if (pk_time + 1'b1 >= overload_duration) begin
              pk_state <= ppm_pkg::PK_HOLD;
            end
          end
          if (pk_time >= peak_cycle_period) begin
            pk_state <= ppm_pkg::PK_HOLD; // Period shorter than overload
          end
        end
        ppm_pkg::PK_HOLD: begin
          if (tick) begin
            pk_time <= pk_time + 1'b1;
            if (pk_time + 1'b1 >= peak_cycle_period) begin
              pk_time <= '0;
              pk_state <= trig ? ppm_pkg::PK_OVLD : ppm_pkg::PK_IDLE;
            end
          end
        end
        default: begin
          pk_state <= ppm_pkg::PK_IDLE;
          pk_time <= '0;
        end
      endcase
    end
  end

  // Limit and charge gating outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      active_limit <= '0;
      peak_level2 <= 1'b0;
      charge_disable <= 1'b0;
      peak_active <= 1'b0;
    end else begin
      peak_level2 <= (pk_state == ppm_pkg::PK_OVLD);
      active_limit <= (pk_state == ppm_pkg::PK_OVLD) ? lim2 : lim1;
      charge_disable <= (pk_state == ppm_pkg::PK_HOLD);
      peak_active <= (pk_state != ppm_pkg::PK_IDLE);
    end
  end
endmodule
`default_nettype wire

// file: test/ppm_ctrl_chk.sv
// Assertion checker for the peak power and monitor control block
`timescale 1ns/1ps
`default_nettype none
module ppm_ctrl_chk #(
  parameter int LIM_W = 7,
  parameter int TIME_W = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire ppm_pkg::ppm_cfg_s cfg_in,
  input wire logic [LIM_W-1:0] input_current_limit,
  input wire logic [7:0] overload_limit_pct,
  input wire logic [TIME_W-1:0] overload_duration,
  input wire ppm_pkg::ppm_sense_s sense_pin,
  input wire logic pulse_skipping_mode,
  input wire logic input_monitor_valid,
  input wire logic power_bus_term_en,
  input wire logic power_bat_term_en,
  input wire logic charge_reduce,
  input wire logic [LIM_W+1:0] active_limit,
  input wire logic peak_level2,
  input wire logic charge_disable,
  input wire logic peak_active
);
  logic [2:0] age;
  logic [TIME_W+6:0] ovl_len;
  logic [LIM_W+8:0] lim2;
  logic trig;
  // Settle count, so history from before reset is never judged
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) age <= 3'h0;
    else if (age != 3'h7) age <= age + 3'h1;
  end
  // Length of the running overload phase
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) ovl_len <= '0;
    else ovl_len <= peak_level2 ? ovl_len + 1'b1 : '0;
  end
  // Reference level two and the raw trigger at the pins
  assign lim2 = (input_current_limit * overload_limit_pct) / 8'd100;
  assign trig = (cfg_in.surge_en && sense_pin.in_over_lim && sense_pin.bat_dischg)
    || (cfg_in.droop_en && sense_pin.sys_below_min && !sense_pin.bat_dischg);
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_MON_OFF:
    assert property (age == 3'h7 && $past(cfg_in.pmon_cfg[1], 2)
      |-> !power_bus_term_en && !power_bat_term_en) else $error("monitor on while off");
  AST_VALID:
    assert property (age == 3'h7 |-> input_monitor_valid == $past(sense_pin.uvlo_ok, 3))
    else $error("monitor valid wrong");
  AST_SKIP:
    assert property (age == 3'h7 |-> pulse_skipping_mode == $past(sense_pin.light_load, 3))
    else $error("pulse skipping wrong");
  AST_REDUCE:
    assert property (age == 3'h7 && $past(sense_pin.in_over_lim || sense_pin.in_under_vlim, 3)
      |-> charge_reduce) else $error("charge not reduced");
  AST_LVL2:
    assert property (peak_level2 && $stable(input_current_limit) && $stable(overload_limit_pct)
      |-> active_limit == lim2[LIM_W+1:0]) else $error("level two limit wrong");
  AST_OVLD_LEN:
    assert property ($fell(peak_level2) && peak_active |-> ovl_len + 40 >= overload_duration * 40
      && ovl_len <= overload_duration * 40 + 40) else $error("overload length wrong");
  AST_HOLD_OFF:
    assert property (peak_active && !peak_level2 |-> charge_disable)
    else $error("charging during hold");
  AST_START:
    assert property (age == 3'h7 && $rose(trig) && !peak_active |-> ##[1:6] peak_active)
    else $error("peak cycle not started");
  AST_IDLE:
    assert property ((!cfg_in.surge_en && !cfg_in.droop_en) [*4] |-> !peak_active)
    else $error("peak cycle without enable");
  // Main scenarios seen
  CVR_RESTART: cover property (charge_disable ##1 peak_level2);
  CVR_HOLD: cover property (peak_active && charge_disable);
  CVR_BUS_ONLY: cover property (power_bus_term_en && !power_bat_term_en);
endmodule
bind ppm_ctrl ppm_ctrl_chk #(.LIM_W(LIM_W), .TIME_W(TIME_W)) u_chk (.clk(clk), .rst_n(rst_n),
  .cfg_in(cfg_in), .input_current_limit(input_current_limit),
  .overload_limit_pct(overload_limit_pct), .overload_duration(overload_duration),
  .sense_pin(sense_pin), .pulse_skipping_mode(pulse_skipping_mode),
  .input_monitor_valid(input_monitor_valid), .power_bus_term_en(power_bus_term_en),
  .power_bat_term_en(power_bat_term_en), .charge_reduce(charge_reduce),
  .active_limit(active_limit), .peak_level2(peak_level2),
  .charge_disable(charge_disable), .peak_active(peak_active));
`default_nettype wire

// file: test/ppm_power_side.sv
// Behavioural adapter, battery and power stage flags
`timescale 1ns/1ps
`default_nettype none
module ppm_power_side (
  input wire logic clk,
  input wire ppm_pkg::ppm_sense_s base,
  input wire logic load_step,
  input wire logic bat_ok,
  input wire logic slow,
  output wire ppm_pkg::ppm_sense_s sense
);
  ppm_pkg::ppm_sense_s now;
  ppm_pkg::ppm_sense_s dly [5];
  // A load step pulls the input over its limit
  always_comb begin
    now = base;
    if (load_step) begin
      now.light_load = 1'b0;
      now.demand = 1'b1;
      now.in_over_lim = 1'b1;
      now.bat_dischg = bat_ok;
      now.sys_below_bat = bat_ok;
      now.sys_below_min = !bat_ok;
    end
  end
  // A slow stage answers five clocks late
  always_ff @(posedge clk) begin
    dly[0] <= now;
    for (int i = 1; i < 5; i++) dly[i] <= dly[i-1];
  end
  assign sense = slow ? dly[4] : now;
endmodule
`default_nettype wire

// file: test/peak_power_and_monitor_control_bench.sv
// Self-checking bench for the peak power and monitor control block
`timescale 1ns/1ps
`default_nettype none
module peak_power_and_monitor_control_bench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  ppm_pkg::ppm_cfg_s cfg = ppm_pkg::CFG_RST;
  ppm_pkg::ppm_sense_s base = '0;
  ppm_pkg::ppm_sense_s sense;
  logic [6:0] lim = 7'h14;
  logic [7:0] pct = 8'h64;
  logic [15:0] odur = 16'h0002;
  logic [15:0] tmax = 16'h0005;
  logic load = 1'b0, bat_ok = 1'b1, slow = 1'b0, pl2_d = 1'b0;
  logic sw, pskip, ghi, bhi, valid, bus_en, bat_en, ra, rb, cred, supp, input_current_optimizer, pl2, cdis, pact;
  logic [8:0] alim;
  logic [8:0] exp_q [$];
  int err_total = 0, checked = 0, seed = 44, cyc = 0, lo, hi, p, s;
  ppm_ctrl uut (.clk(clk), .rst_n(rst_n), .cfg_in(cfg), .input_current_limit(lim),
    .overload_limit_pct(pct), .overload_duration(odur), .peak_cycle_period(tmax),
    .sense_pin(sense), .switch_pulse(sw), .pulse_skipping_mode(pskip),
    .input_monitor_gain_hi(ghi), .battery_monitor_gain_hi(bhi), .input_monitor_valid(valid),
    .power_bus_term_en(bus_en), .power_bat_term_en(bat_en), .input_res_5m(ra),
    .battery_res_5m(rb), .charge_reduce(cred), .battery_supplement(supp), .ico_allowed(input_current_optimizer),
    .active_limit(alim), .peak_level2(pl2), .charge_disable(cdis), .peak_active(pact));
  ppm_power_side u_side (.clk(clk), .base(base), .load_step(load), .bat_ok(bat_ok),
    .slow(slow), .sense(sense));
  initial forever #12.5 clk = ~clk;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (err_total == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Shortest and longest gap between switching pulses
  task automatic gaps(input int n);
    int g;
    lo = 99999;
    hi = 0;
    @(negedge clk iff sw);
    repeat (n) begin
      g = 0;
      do begin @(negedge clk); g++; end while (!sw && g < 4000);
      if (g < lo) lo = g;
      if (g > hi) hi = g;
    end
  endtask
  // Expected bus and battery term enables
  function automatic logic [1:0] pmon_exp(input logic [1:0] pm, input logic ob, input logic og);
    case (pm)
      2'h0: return {!(og && ob), 1'b1};
      2'h1: return {!og, 1'b0};
      default: return 2'h0;
    endcase
  endfunction
  // Hang guard, a run needs well under this
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_total++;
      tally_and_finish();
    end
  end
  // Each overload entry is judged against the oldest noted limit
  always @(negedge clk) begin
    pl2_d <= pl2;
    if (pl2 && !pl2_d) chk(alim, exp_q.size() ? exp_q.pop_front() : 9'h1ff);
  end
  initial begin
    base.demand = 1'b1;
    base.uvlo_ok = 1'b1;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    gaps(20);
    chk({bus_en, bat_en, lo[5:0], hi[5:0]}, {2'h0, 6'd50, 6'd50});
    // Monitor term settings swept, gains and flags with random values
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      cfg.pmon_cfg <= i[1:0];
      cfg.otg_bat_only <= i[2];
      base.otg_mode <= i[3];
      {cfg.in_gain_hi, cfg.bat_gain_hi, cfg.in_res_5m, cfg.bat_res_5m} <= 4'($random(seed));
      {base.uvlo_ok, base.in_over_lim, base.in_under_vlim, base.sys_below_bat} <= 4'($random(seed));
      repeat (6) @(posedge clk);
      @(negedge clk);
      chk({bus_en, bat_en}, pmon_exp(cfg.pmon_cfg, cfg.otg_bat_only, base.otg_mode));
      chk({ghi, bhi, ra, rb}, {cfg.in_gain_hi, cfg.bat_gain_hi, cfg.in_res_5m, cfg.bat_res_5m});
      p = base.in_over_lim || base.in_under_vlim;
      chk({valid, cred, supp}, {base.uvlo_ok, p[0], p[0] && base.sys_below_bat});
    end
    @(posedge clk);
    base <= '{demand: 1'b1, uvlo_ok: 1'b1, default: 1'b0};
    cfg.ico_request <= 1'b1;
    // Optimizer limit boundary
    for (int v = 9; v < 11; v++) begin
      @(posedge clk);
      lim <= v[6:0];
      repeat (4) @(posedge clk);
      @(negedge clk);
      chk(input_current_optimizer, v == 10);
    end
    // Every spread code at both fixed frequencies
    for (int f = 0; f < 8; f++) begin
      @(posedge clk);
      cfg.freq_sel <= f[2];
      cfg.spread_sel <= f[1:0];
      p = f[2] ? 34 : 50;
      s = p * (f[1:0] * 2) / 100;
      gaps(20);
      gaps(4 * s + 8);
      chk(lo, p - s);
      chk(hi, p + s);
    end
    @(posedge clk);
    base.light_load <= 1'b1;
    base.demand <= 1'b0;
    cfg.noise_guard_en <= 1'b1;
    gaps(3);
    gaps(3);
    chk({lo[15:0], hi[15:0]} == {16'd1600, 16'd1600}, 1'b1);
    chk(pskip, 1'b1);
    // Surge with discharge, held over two cycles
    @(posedge clk);
    base.light_load <= 1'b0;
    base.demand <= 1'b1;
    lim <= 7'h14;
    pct <= 8'h96;
    cfg.surge_en <= 1'b1;
    repeat (4) @(posedge clk);
    exp_q.push_back(9'h01e);
    exp_q.push_back(9'h01e);
    load <= 1'b1;
    repeat (150) @(posedge clk);
    @(negedge clk);
    chk({pact, pl2, cdis}, 3'h5);
    repeat (150) @(posedge clk);
    load <= 1'b0;
    repeat (300) @(posedge clk);
    chk(exp_q.size(), 0);
    // Adapter-only droop from a slow stage, then enables cleared
    cfg.surge_en <= 1'b0;
    cfg.droop_en <= 1'b1;
    bat_ok <= 1'b0;
    slow <= 1'b1;
    pct <= 8'h7d;
    odur <= 16'h0003;
    tmax <= 16'h0007;
    exp_q.push_back(9'h019);
    repeat (4) @(posedge clk);
    load <= 1'b1;
    repeat (200) @(posedge clk);
    @(negedge clk);
    chk({pact, pl2, cdis}, 3'h5);
    @(posedge clk);
    cfg.droop_en <= 1'b0;
    repeat (6) @(posedge clk);
    @(negedge clk);
    chk({pact, exp_q.size() == 0}, 2'h1);
    tally_and_finish();
  end
endmodule
`default_nettype wire
